// ==== core/gsr_pkg.sv ====
// Constants and types for the yaw-rate SPI command readout
package gsr_pkg;

    // ==========================================================
    // Instruction codes and argument lengths in bytes
    localparam logic [7:0]  INS_RATE       = 8'h50;
    localparam logic [7:0]  INS_TEMP       = 8'h54;
    localparam logic [7:0]  INS_ADV_RD     = 8'h58;
    localparam logic [7:0]  INS_ADV_WR     = 8'h78;
    localparam logic [7:0]  INS_ADV_STAT   = 8'h7C;
    localparam logic [3:0]  LEN_RATE       = 4'h4;
    localparam logic [3:0]  LEN_TEMP       = 4'h2;
    localparam logic [3:0]  LEN_ADV_RD     = 4'h4;
    localparam logic [3:0]  LEN_ADV_WR     = 4'h8;
    localparam logic [3:0]  LEN_ADV_STAT   = 4'h2;

    // ==========================================================
    // Advanced write operations and result codes
    localparam logic [7:0]  OP_SYS_WR      = 8'h01;
    localparam logic [7:0]  OP_MTP_WR      = 8'h02;
    localparam logic [7:0]  OP_SYS_SEL     = 8'h03;
    localparam logic [7:0]  OP_MTP_SEL     = 8'h04;
    localparam logic [7:0]  RES_NONE       = 8'h00;
    localparam logic [7:0]  RES_OK         = 8'h01;
    localparam logic [7:0]  RES_REFUSED    = 8'h02;

    // ==========================================================
    // Memory map of system registers and programmable memory
    localparam int          AW             = 6;
    localparam int          DEPTH          = 64;
    localparam logic [5:0]  ADDR_LAST      = 6'h3F;
    localparam logic [5:0]  ADDR_GYRO_CFG  = 6'h02;
    localparam int          BIT_GYRO_BYP   = 27;
    localparam int          SLOT_LSB       = 8;
    localparam logic [7:0]  SLOT_RESET     = 8'h01;
    localparam logic [5:0]  ADDR_TEMP_CFG  = 6'h09;
    localparam int          BIT_THERM_SEL  = 2;
    localparam logic [5:0]  ADDR_TCAL      = 6'h04;
    localparam int          TGAIN_LSB      = 2;
    localparam logic [11:0] TGAIN_RESET    = 12'h800;
    localparam logic [5:0]  ADDR_RCAL_LO   = 6'h2E;
    localparam logic [5:0]  ADDR_RCAL_HI   = 6'h33;
    localparam logic [2:0]  MTP_LIM_RCAL   = 3'h7;
    localparam logic [2:0]  MTP_LIM_OTHER  = 3'h1;

    // ==========================================================
    // Frame layouts
    localparam int          RATE_LSB       = 8;
    localparam int          NEW_BIT        = 1;
    localparam int          HEALTH_BIT     = 0;
    localparam int          RATE_LSB_PER_DPS = 10000;

    typedef enum logic [0:0] {S_RELOAD, S_RUN} gsr_state_t;

    function automatic logic [3:0] gsr_arg_len(input logic [7:0] ins);
        case (ins)
            INS_RATE:     gsr_arg_len = LEN_RATE;
            INS_TEMP:     gsr_arg_len = LEN_TEMP;
            INS_ADV_RD:   gsr_arg_len = LEN_ADV_RD;
            INS_ADV_WR:   gsr_arg_len = LEN_ADV_WR;
            INS_ADV_STAT: gsr_arg_len = LEN_ADV_STAT;
            default:      gsr_arg_len = 4'h0;
        endcase
    endfunction

endpackage

// ==== core/gsr_mem.sv ====
// System register and programmable memory store
`timescale 1ns/1ps
module gsr_mem (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     copy_en,
    input  wire logic [gsr_pkg::AW-1:0]   copy_addr,
    input  wire logic                     sys_we,
    input  wire logic                     mtp_we,
    input  wire logic [gsr_pkg::AW-1:0]   wr_addr,
    input  wire logic [31:0]              wr_data,
    input  wire logic                     rd_mtp,
    input  wire logic [gsr_pkg::AW-1:0]   rd_addr,
    output logic      [31:0]              rd_data,
    output logic                          mtp_ok,
    output logic                          bypass_bit,
    output logic                          therm_bit
);
    logic [31:0] sys_mem [0:gsr_pkg::DEPTH-1];
    logic [31:0] mtp_mem [0:gsr_pkg::DEPTH-1];
    logic [2:0]  mtp_cnt [0:gsr_pkg::DEPTH-1];
    logic [31:0] next_rd_data;
    logic [2:0]  lim;
    logic [2:0]  cnt_wr;

    // ==========================================================
    // Factory content
    initial begin
        for (int i = 0; i < gsr_pkg::DEPTH; i++) begin
            mtp_mem[i] = 32'h0000_0000;
            mtp_cnt[i] = 3'h0;
        end
        mtp_mem[gsr_pkg::ADDR_TCAL][gsr_pkg::TGAIN_LSB +: 12] = gsr_pkg::TGAIN_RESET;
        mtp_mem[gsr_pkg::ADDR_GYRO_CFG][gsr_pkg::SLOT_LSB +: 8] = gsr_pkg::SLOT_RESET;
    end

    // ==========================================================
    // Write limits
    always_comb begin
        cnt_wr = mtp_cnt[wr_addr];
        lim    = gsr_pkg::MTP_LIM_OTHER;
        if (wr_addr >= gsr_pkg::ADDR_RCAL_LO && wr_addr <= gsr_pkg::ADDR_RCAL_HI) begin
            lim = gsr_pkg::MTP_LIM_RCAL;
        end
        mtp_ok       = cnt_wr < lim;
        next_rd_data = rd_mtp ? mtp_mem[rd_addr] : sys_mem[rd_addr];
        bypass_bit   = sys_mem[gsr_pkg::ADDR_GYRO_CFG][gsr_pkg::BIT_GYRO_BYP];
        therm_bit    = sys_mem[gsr_pkg::ADDR_TEMP_CFG][gsr_pkg::BIT_THERM_SEL];
    end

    // Permanent store, never reset
    always @(posedge clk) begin
        if (mtp_we && mtp_ok) begin
            mtp_mem[wr_addr] <= wr_data;
            mtp_cnt[wr_addr] <= cnt_wr + 3'h1;
        end
    end

    // Volatile store, refilled after reset
    always_ff @(posedge clk) begin
        if (copy_en) begin
            sys_mem[copy_addr] <= mtp_mem[copy_addr];
        end else if (sys_we) begin
            sys_mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 32'h0000_0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    property p_mtp_limit;
        @(posedge clk) disable iff (!rst_n)
        cnt_wr <= lim;
    endproperty
    a_mtp_limit: assert property (p_mtp_limit) else $error("Write count above limit");

endmodule

// ==== core/gsr_top.sv ====
// Yaw-rate sensor SPI command readout, device side
`timescale 1ns/1ps
module gsr_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        SCLK,
    input  wire logic        SSB_N,
    input  wire logic        MOSI,
    output logic             MISO,
    output logic             MISO_OE,
    input  wire logic [23:0] RATE_DATA,
    input  wire logic        RATE_STROBE,
    input  wire logic [11:0] TEMP_DATA,
    input  wire logic        DRIVE_STABLE,
    output logic             HEALTH,
    output logic             GYRO_COMP_BYPASS,
    output logic             THERMAL_CAL_SELECT
);
    // ==========================================================
    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ==========================================================
    // Link side: bit capture on rising clock
    logic        link_clr;
    logic [6:0]  bits;
    logic [6:0]  next_bits;
    logic [7:0]  instr;
    logic [7:0]  next_instr;
    logic [63:0] args;
    logic [63:0] next_args;
    logic [3:0]  len;
    logic        frame_last;

    assign link_clr = SSB_N | ~rst_n;

    always_comb begin
        next_bits  = (bits == 7'h7F) ? bits : bits + 7'h01;
        next_args  = {args[62:0], MOSI};
        next_instr = instr;
        if (bits == 7'h07) begin
            next_instr = {args[6:0], MOSI};
        end
        len        = gsr_pkg::gsr_arg_len(instr);
        frame_last = (len != 4'h0) && (bits == ({len[3:0], 3'b000} - 7'h01 + 7'h08));
    end

    always_ff @(posedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            bits  <= 7'h00;
            instr <= 8'h00;
            args  <= 64'h0;
        end else begin
            bits  <= next_bits;
            instr <= next_instr;
            args  <= next_args;
        end
    end

    // Completed frame, held for the system side
    logic        done_tog;
    logic        next_done_tog;
    logic [7:0]  instr_cap;
    logic [7:0]  next_instr_cap;
    logic [63:0] args_cap;
    logic [63:0] next_args_cap;

    always_comb begin
        next_done_tog  = done_tog;
        next_instr_cap = instr_cap;
        next_args_cap  = args_cap;
        if (frame_last) begin
            next_done_tog  = ~done_tog;
            next_instr_cap = instr;
            next_args_cap  = next_args;
        end
    end

    always_ff @(posedge SCLK or negedge rst_n) begin
        if (!rst_n) begin
            done_tog  <= 1'b0;
            instr_cap <= 8'h00;
            args_cap  <= 64'h0;
        end else begin
            done_tog  <= next_done_tog;
            instr_cap <= next_instr_cap;
            args_cap  <= next_args_cap;
        end
    end

    // ==========================================================
    // Link side: answer shifted on falling clock
    logic [63:0] tx;
    logic [63:0] next_tx;
    logic [31:0] rate_frame;
    logic [15:0] temp_frame;
    logic [31:0] adv_word;
    logic [15:0] stat_word;
    logic        next_oe;

    always_comb begin
        next_tx = {tx[62:0], 1'b0};
        if (bits == 7'h08) begin
            case (instr)
                gsr_pkg::INS_RATE:     next_tx = {rate_frame, 32'h0000_0000};
                gsr_pkg::INS_TEMP:     next_tx = {temp_frame, 48'h0};
                gsr_pkg::INS_ADV_RD:   next_tx = {adv_word, 32'h0000_0000};
                gsr_pkg::INS_ADV_STAT: next_tx = {stat_word, 48'h0};
                default:               next_tx = 64'h0;
            endcase
        end
        next_oe = 1'b1;
    end

    always_ff @(negedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            tx <= 64'h0;
        end else begin
            tx <= next_tx;
        end
    end

    always_ff @(posedge SCLK or posedge link_clr) begin
        if (link_clr) begin
            MISO_OE <= 1'b0;
        end else begin
            MISO_OE <= next_oe;
        end
    end

    assign MISO = tx[63];

    // ==========================================================
    // Crossings into the system clock
    logic ssb_meta;
    logic ssb_idle;
    logic tog_meta;
    logic tog_s;
    logic tog_d;
    logic frame_evt;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ssb_meta <= 1'b1;
            ssb_idle <= 1'b1;
            tog_meta <= 1'b0;
            tog_s    <= 1'b0;
            tog_d    <= 1'b0;
        end else begin
            ssb_meta <= SSB_N;
            ssb_idle <= ssb_meta;
            tog_meta <= done_tog;
            tog_s    <= tog_meta;
            tog_d    <= tog_s;
        end
    end

    assign frame_evt = tog_s ^ tog_d;

    // ==========================================================
    // Measurement flags, memory control and answer snapshots
    gsr_pkg::gsr_state_t state;
    gsr_pkg::gsr_state_t next_state;
    logic [5:0]  reload_addr;
    logic [5:0]  next_reload_addr;
    logic [23:0] rate_word;
    logic [23:0] next_rate_word;
    logic        new_sample;
    logic        next_new_sample;
    logic        health;
    logic        next_health;
    logic [5:0]  rd_addr;
    logic [5:0]  next_rd_addr;
    logic        rd_mtp;
    logic        next_rd_mtp;
    logic [7:0]  result;
    logic [7:0]  next_result;
    logic [31:0] next_rate_frame;
    logic [15:0] next_temp_frame;
    logic [31:0] next_adv_word;
    logic [15:0] next_stat_word;
    logic        next_bypass;
    logic        next_therm;
    logic        run;
    logic        adv_wr;
    logic        rate_read;
    logic [7:0]  op;
    logic        sys_we;
    logic        mtp_we;
    logic        mtp_ok;
    logic [31:0] mem_rd;
    logic        mem_bypass;
    logic        mem_therm;

    always_comb begin
        run       = state == gsr_pkg::S_RUN;
        op        = args_cap[63:56];
        adv_wr    = frame_evt && run && instr_cap == gsr_pkg::INS_ADV_WR;
        rate_read = frame_evt && instr_cap == gsr_pkg::INS_RATE;
        sys_we    = adv_wr && op == gsr_pkg::OP_SYS_WR;
        mtp_we    = adv_wr && op == gsr_pkg::OP_MTP_WR;

        next_state       = state;
        next_reload_addr = reload_addr;
        case (state)
            gsr_pkg::S_RELOAD: begin
                next_reload_addr = reload_addr + 6'h01;
                if (reload_addr == gsr_pkg::ADDR_LAST) begin
                    next_state = gsr_pkg::S_RUN;
                end
            end
            gsr_pkg::S_RUN: next_state = gsr_pkg::S_RUN;
            default:        next_state = gsr_pkg::S_RELOAD;
        endcase

        next_rate_word  = rate_word;
        next_health     = health;
        if (RATE_STROBE) begin
            next_rate_word = RATE_DATA;
            next_health    = DRIVE_STABLE;
        end
        next_new_sample = (new_sample & ~rate_read) | RATE_STROBE;

        next_rd_addr = rd_addr;
        next_rd_mtp  = rd_mtp;
        next_result  = result;
        if (adv_wr) begin
            next_result = gsr_pkg::RES_OK;
            case (op)
                gsr_pkg::OP_SYS_WR:  next_result = gsr_pkg::RES_OK;
                gsr_pkg::OP_MTP_WR:  next_result = mtp_ok ? gsr_pkg::RES_OK : gsr_pkg::RES_REFUSED;
                gsr_pkg::OP_SYS_SEL: begin
                    next_rd_addr = args_cap[53:48];
                    next_rd_mtp  = 1'b0;
                end
                gsr_pkg::OP_MTP_SEL: begin
                    next_rd_addr = args_cap[53:48];
                    next_rd_mtp  = 1'b1;
                end
                default:             next_result = gsr_pkg::RES_REFUSED;
            endcase
        end

        // Rate LSB weight is 1/RATE_LSB_PER_DPS dps when compensated
        next_rate_frame = 32'h0000_0000;
        next_rate_frame[31:gsr_pkg::RATE_LSB]  = rate_word;
        next_rate_frame[gsr_pkg::NEW_BIT]      = new_sample;
        next_rate_frame[gsr_pkg::HEALTH_BIT]   = health;
        next_temp_frame = {4'h0, TEMP_DATA};
        next_adv_word   = mem_rd;
        next_stat_word  = {8'h00, result};
        if (!ssb_idle) begin
            next_rate_frame = rate_frame;
            next_temp_frame = temp_frame;
            next_adv_word   = adv_word;
            next_stat_word  = stat_word;
        end
        next_bypass = run & mem_bypass;
        next_therm  = run & mem_therm;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state              <= gsr_pkg::S_RELOAD;
            reload_addr        <= 6'h00;
            rate_word          <= 24'h00_0000;
            new_sample         <= 1'b0;
            health             <= 1'b0;
            rd_addr            <= 6'h00;
            rd_mtp             <= 1'b0;
            result             <= gsr_pkg::RES_NONE;
            rate_frame         <= 32'h0000_0000;
            temp_frame         <= 16'h0000;
            adv_word           <= 32'h0000_0000;
            stat_word          <= 16'h0000;
            HEALTH             <= 1'b0;
            GYRO_COMP_BYPASS   <= 1'b0;
            THERMAL_CAL_SELECT <= 1'b0;
        end else begin
            state              <= next_state;
            reload_addr        <= next_reload_addr;
            rate_word          <= next_rate_word;
            new_sample         <= next_new_sample;
            health             <= next_health;
            rd_addr            <= next_rd_addr;
            rd_mtp             <= next_rd_mtp;
            result             <= next_result;
            rate_frame         <= next_rate_frame;
            temp_frame         <= next_temp_frame;
            adv_word           <= next_adv_word;
            stat_word          <= next_stat_word;
            HEALTH             <= health;
            GYRO_COMP_BYPASS   <= next_bypass;
            THERMAL_CAL_SELECT <= next_therm;
        end
    end

    gsr_mem u_mem (
        .clk        (CLK),
        .rst_n      (rst_n),
        .copy_en    (state == gsr_pkg::S_RELOAD),
        .copy_addr  (reload_addr),
        .sys_we     (sys_we),
        .mtp_we     (mtp_we),
        .wr_addr    (args_cap[53:48]),
        .wr_data    (args_cap[47:16]),
        .rd_mtp     (rd_mtp),
        .rd_addr    (rd_addr),
        .rd_data    (mem_rd),
        .mtp_ok     (mtp_ok),
        .bypass_bit (mem_bypass),
        .therm_bit  (mem_therm)
    );

    // ==========================================================
    // Checks
    sequence s_rate_read;
        frame_evt && instr_cap == gsr_pkg::INS_RATE;
    endsequence

    property p_new_set;
        @(posedge CLK) disable iff (!rst_n)
        RATE_STROBE |=> new_sample;
    endproperty
    a_new_set: assert property (p_new_set) else $error("New-sample flag not set");

    property p_new_clr;
        @(posedge CLK) disable iff (!rst_n)
        s_rate_read ##0 !RATE_STROBE |=> !new_sample;
    endproperty
    a_new_clr: assert property (p_new_clr) else $error("New-sample flag not cleared");

    property p_health;
        @(posedge CLK) disable iff (!rst_n)
        RATE_STROBE |=> ##1 HEALTH == $past(DRIVE_STABLE, 2);
    endproperty
    a_health: assert property (p_health) else $error("Health pin wrong");

    property p_health_pin;
        @(posedge CLK) disable iff (!rst_n)
        !RATE_STROBE [*2] |-> HEALTH == health;
    endproperty
    a_health_pin: assert property (p_health_pin) else $error("Health pin mismatch");

    property p_oe_off;
        @(posedge CLK) disable iff (!rst_n)
        SSB_N |-> !MISO_OE;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("Output driven while deselected");

    property p_reload;
        @(posedge CLK) disable iff (!rst_n)
        $rose(run) |-> $past(reload_addr) == gsr_pkg::ADDR_LAST && !$past(sys_we);
    endproperty
    a_reload: assert property (p_reload) else $error("Reload ended early");

    property p_bypass;
        @(posedge CLK) disable iff (!rst_n)
        run && $past(run) |=> GYRO_COMP_BYPASS == $past(mem_bypass);
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypass output stale");

    property p_frame_done;
        @(negedge SCLK) disable iff (link_clr)
        len != 4'h0 && bits == ({len, 3'b000} + 7'h08) |-> done_tog != $past(done_tog);
    endproperty
    a_frame_done: assert property (p_frame_done) else $error("Frame end not flagged");

endmodule

// ==== tb/gsr_spi_host.sv ====
// SPI mode 0 master model for the sensor link
`timescale 1ns/1ps
module gsr_spi_host (
    output logic      sclk,
    output logic      ssb_n,
    output logic      mosi,
    input  wire logic miso
);
    // ========
    // Idle link
    initial begin
        sclk  = 1'b0;
        ssb_n = 1'b1;
        mosi  = 1'b0;
    end

    // ========
    // One frame, instruction first, MSB first
    task automatic xfer(input int n, input logic [71:0] tx, output logic [31:0] rx);
        logic [71:0] sh;
        sh = tx;
        rx = 32'h0;
        ssb_n = 1'b0;
        #12;
        for (int i = 0; i < n; i++) begin
            mosi = sh[71];
            sh = sh << 1;
            #6 sclk = 1'b1;
            rx = {rx[30:0], miso};
            #6 sclk = 1'b0;
        end
        #12 ssb_n = 1'b1;
        mosi = ~mosi;
        #200;
    endtask
endmodule

// ==== tb/gyro_spi_command_readout_test.sv ====
// Self-checking bench for the yaw-rate SPI command readout
`timescale 1ns/1ps
module gyro_spi_command_readout_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sclk, ssb_n, mosi, miso, miso_oe, health, byp, tsel;
    logic [23:0] rate = 24'h0;
    logic        stb = 1'b0;
    logic [11:0] temp = 12'h0;
    logic        stable = 1'b0;
    logic [31:0] rx;
    wire         miso_line;
    int          err_count = 0;
    int          samples_checked = 0;

    always #20 clk = ~clk;

    gsr_top gsr_top_inst (.CLK(clk), .RST_N(rst_n), .SCLK(sclk), .SSB_N(ssb_n), .MOSI(mosi),
        .MISO(miso), .MISO_OE(miso_oe), .RATE_DATA(rate), .RATE_STROBE(stb), .TEMP_DATA(temp),
        .DRIVE_STABLE(stable), .HEALTH(health), .GYRO_COMP_BYPASS(byp), .THERMAL_CAL_SELECT(tsel));
    // Undriven line shows the inverse of the pin
    assign miso_line = miso_oe ? miso : ~miso;
    gsr_spi_host gsr_spi_host_inst (.sclk(sclk), .ssb_n(ssb_n), .mosi(mosi), .miso(miso_line));

    // ========
    // Tasks
    task automatic stop_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic strobe(input logic [23:0] r, input logic ok);
        rate = r;
        stable = ok;
        stb = 1'b1;
        cyc(1);
        stb = 1'b0;
        cyc(4);
    endtask
    task automatic do_reset;
        rst_n = 1'b0;
        cyc(6);
        rst_n = 1'b1;
        cyc(80);
    endtask
    task automatic frame(input logic [7:0] ins, input int nb);
        gsr_spi_host_inst.xfer(8 + nb * 8, {ins, 64'h0}, rx);
        cyc(8);
    endtask
    task automatic adv(input logic [7:0] op, input logic [5:0] a, input logic [31:0] d, input logic [7:0] res);
        gsr_spi_host_inst.xfer(72, {gsr_pkg::INS_ADV_WR, op, 2'b00, a, d, 16'h0}, rx);
        cyc(8);
        frame(gsr_pkg::INS_ADV_STAT, 2);
        chk_word({16'h0, rx[15:0]}, {24'h0, res});
    endtask

    // ========
    // Watchdog
    initial begin
        #400000;
        err_count++;
        stop_test;
    end

    // ========
    // Tests
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cyc(80);
        chk_bit(byp, 1'b0);
        chk_bit(tsel, 1'b0);
        strobe(24'hA47280, 1'b1);
        chk_bit(health, 1'b1);
        frame(gsr_pkg::INS_RATE, 4);
        chk_word(rx, {24'hA47280, 8'h03});
        frame(gsr_pkg::INS_RATE, 4);
        chk_word(rx, {24'hA47280, 8'h01});
        strobe(24'h2DC6C0, 1'b0);
        chk_bit(health, 1'b0);
        frame(8'h51, 4);
        chk_word(rx, 32'h0);
        frame(gsr_pkg::INS_RATE, 4);
        chk_word(rx, {24'h2DC6C0, 8'h02});
        temp = 12'hABC;
        frame(gsr_pkg::INS_TEMP, 2);
        chk_word({16'h0, rx[15:0]}, 32'h0ABC);
        adv(gsr_pkg::OP_SYS_WR, 6'h02, 32'h0800_0100, gsr_pkg::RES_OK);
        chk_bit(byp, 1'b1);
        frame(gsr_pkg::INS_RATE, 4);
        chk_word(rx, {24'h2DC6C0, 8'h00});
        adv(gsr_pkg::OP_SYS_WR, 6'h02, 32'h0000_0100, gsr_pkg::RES_OK);
        chk_bit(byp, 1'b0);
        adv(gsr_pkg::OP_SYS_WR, 6'h02, 32'h0800_0100, gsr_pkg::RES_OK);
        adv(gsr_pkg::OP_SYS_WR, 6'h09, 32'h0000_0004, gsr_pkg::RES_OK);
        chk_bit(tsel, 1'b1);
        adv(gsr_pkg::OP_SYS_SEL, 6'h02, 32'h0, gsr_pkg::RES_OK);
        frame(gsr_pkg::INS_ADV_RD, 4);
        chk_word(rx, 32'h0800_0100);
        adv(8'h05, 6'h02, 32'h0, gsr_pkg::RES_REFUSED);
        chk_bit(byp, 1'b1);
        do_reset;
        chk_bit(byp, 1'b0);
        chk_bit(tsel, 1'b0);
        frame(gsr_pkg::INS_ADV_STAT, 2);
        chk_word({16'h0, rx[15:0]}, {24'h0, gsr_pkg::RES_NONE});
        adv(gsr_pkg::OP_MTP_WR, 6'h09, 32'h0000_0004, gsr_pkg::RES_OK);
        adv(gsr_pkg::OP_MTP_WR, 6'h09, 32'h0, gsr_pkg::RES_REFUSED);
        for (int i = 1; i <= 8; i++) begin
            adv(gsr_pkg::OP_MTP_WR, 6'h2E, 32'(i), i < 8 ? gsr_pkg::RES_OK : gsr_pkg::RES_REFUSED);
        end
        do_reset;
        chk_bit(tsel, 1'b1);
        adv(gsr_pkg::OP_MTP_SEL, 6'h2E, 32'h0, gsr_pkg::RES_OK);
        frame(gsr_pkg::INS_ADV_RD, 4);
        chk_word(rx, 32'h7);
        chk_bit(miso_oe, 1'b0);
        stop_test;
    end
endmodule
